/* File: verilog/scbc_pkg.sv */
// shared constants for the signed compare and decimal convert datapath
package scbc_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_OPA_LO = 8'h04;
   localparam logic [7:0] OFS_OPA_HI = 8'h08;
   localparam logic [7:0] OFS_OPB_LO = 8'h0c;
   localparam logic [7:0] OFS_OPB_HI = 8'h10;
   localparam logic [7:0] OFS_RES_LO = 8'h14;
   localparam logic [7:0] OFS_RES_HI = 8'h18;
   localparam logic [7:0] OFS_FLAGS = 8'h1c;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
   localparam logic [7:0] OFS_PTR = 8'h24;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
   // ==========================================================
   // control register fields
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_EXEC_BIT = 4;
   localparam int CTRL_IND_BIT = 5;
   localparam int CTRL_GO_BIT = 7;
   localparam logic [1:0] OP_NONE = 2'h0;
   localparam logic [1:0] OP_CMP = 2'h1;
   localparam logic [1:0] OP_CVT_WORD = 2'h2;
   localparam logic [1:0] OP_CVT_LONG = 2'h3;
   // ==========================================================
   // flag register fields
   localparam int FLG_ABOVE_BIT = 0;
   localparam int FLG_MATCH_BIT = 1;
   localparam int FLG_BELOW_BIT = 2;
   localparam int FLG_FAULT_BIT = 3;
   localparam int FLG_BUSY_BIT = 4;
   // ==========================================================
   // interrupt status fields
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_FAULT_BIT = 1;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;
   // ==========================================================
   // conversion lengths and bus answers
   localparam logic [3:0] DIGITS_WORD = 4'h4;
   localparam logic [3:0] DIGITS_LONG = 4'h8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // true when every nibble is a decimal digit
   function automatic logic is_bcd16(input logic [15:0] v);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (v[4*i +: 4] > 4'h9) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction : is_bcd16
endpackage : scbc_pkg

/* File: verilog/scbc_digit_conv.sv */
// serial decimal-digit to binary converter, one digit per clock
module scbc_digit_conv (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [3:0] ndigits,
   input wire logic [31:0] src,
   output logic done,
   output logic bad,
   output logic [31:0] value
);
   // ==========================================================
   // state
   typedef struct packed {
      logic [31:0] acc;
      logic [31:0] sh;
      logic [3:0] cnt;
      logic busy;
      logic bad;
      logic done;
   } scbc_dc_t;

   scbc_dc_t s_q, s_d;
   logic [3:0] nib;

   // ==========================================================
   // next state
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      nib = s_q.sh[31:28];
      if (start) begin
         // short words are left aligned so the top digit goes first
         s_d.sh = (ndigits == scbc_pkg::DIGITS_WORD) ? {src[15:0], 16'h0000} : src;
         s_d.cnt = ndigits;
         s_d.acc = 32'h0000_0000;
         s_d.bad = 1'b0;
         s_d.busy = 1'b1;
      end else if (s_q.busy) begin
         if (nib > 4'h9) begin
            s_d.bad = 1'b1;
         end
         s_d.acc = (s_q.acc << 3) + (s_q.acc << 1) + {28'h0, nib};
         s_d.sh = {s_q.sh[27:0], 4'h0};
         s_d.cnt = s_q.cnt - 4'h1;
         if (s_q.cnt == 4'h1) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign done = s_q.done;
   assign bad = s_q.bad;
   assign value = s_q.acc;
endmodule : scbc_digit_conv

/* File: verilog/scbc_top.sv */
// signed long compare and decimal-to-binary conversion unit, AXI4-Lite slave
// Operation
// - the compare takes each operand as a 32-bit two's complement value, high word upper.
// - a smaller first operand sets the below flag and clears match and above.
// - a larger first operand sets the above flag and clears match and below.
// - an indirect pointer that is not decimal or past the area end sets the fault flag.
// - with the execution condition false no instruction changes any flag or word.
// - the word conversion turns four decimal digits into the equal binary result word.
// - the word conversion faults on any non-decimal digit.
// - the long conversion turns eight decimal digits from two words into a 32-bit result.
// - the long conversion faults on any non-decimal digit in either word.
// - both conversions set match on a zero result and clear it on a nonzero one; a faulting conversion leaves match unchanged.
// - conversions write only the result words and never the sources.
module scbc_top #(
   parameter logic [15:0] AREA_LAST_BCD = 16'h9999
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq
);
   // ==========================================================
   // elaboration checks
   // the area end is compared digit-wise, so it must be decimal
   if (!scbc_pkg::is_bcd16(AREA_LAST_BCD)) begin : g_bad_area
      $error("AREA_LAST_BCD must hold decimal digits only");
   end

   // ==========================================================
   // state
   typedef enum logic [1:0] {
      SCBC_IDLE = 2'b01,
      SCBC_CONV = 2'b10
   } scbc_state_t;

   typedef struct packed {
      scbc_state_t st;
      logic [1:0] op;
      logic [15:0] opa_lo;
      logic [15:0] opa_hi;
      logic [15:0] opb_lo;
      logic [15:0] opb_hi;
      logic [15:0] ptr;
      logic [15:0] res_lo;
      logic [15:0] res_hi;
      logic above;
      logic match;
      logic below;
      logic fault;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic irq;
      logic aw_held;
      logic [7:0] awaddr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } scbc_regs_t;

   scbc_regs_t r_q, r_d;
   logic cv_start;
   logic [3:0] cv_ndigits;
   logic cv_done;
   logic cv_bad;
   logic [31:0] cv_value;

   // ==========================================================
   // converter
   scbc_digit_conv u_conv (
      .clk(clk),
      .rst(rst),
      .start(cv_start),
      .ndigits(cv_ndigits),
      .src({r_q.opa_hi, r_q.opa_lo}),
      .done(cv_done),
      .bad(cv_bad),
      .value(cv_value)
   );

   // ==========================================================
   // next state
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
      // upper bytes of the bus word are ignored, registers are 16 bits
      logic [15:0] v;
      v = old;
      if (be[0]) begin
         v[7:0] = wd[7:0];
      end
      if (be[1]) begin
         v[15:8] = wd[15:8];
      end
      return v;
   endfunction : merge16

   logic do_write;
   logic do_read;
   logic map_ok;
   logic go;
   logic ptr_fault;
   logic [1:0] ev;
   logic [1:0] go_op;
   logic go_exec;
   logic signed [31:0] cmp_a;
   logic signed [31:0] cmp_b;

   always_comb begin
      r_d = r_q;
      ev = 2'b00;
      cv_start = 1'b0;
      cv_ndigits = scbc_pkg::DIGITS_LONG;
      go = 1'b0;
      map_ok = 1'b1;
      go_op = r_q.wdata[scbc_pkg::CTRL_OP_LSB +: 2];
      go_exec = r_q.wdata[scbc_pkg::CTRL_EXEC_BIT];
      // both halves joined, compared as signed
      cmp_a = {r_q.opa_hi, r_q.opa_lo};
      cmp_b = {r_q.opb_hi, r_q.opb_lo};
      ptr_fault = r_q.wdata[scbc_pkg::CTRL_IND_BIT] &&
                  (!scbc_pkg::is_bcd16(r_q.ptr) || (r_q.ptr > AREA_LAST_BCD));

      // ========================================================
      // bus handshakes
      // address and data are taken in either order
      if (s_axi_awvalid && r_q.awready) begin
         r_d.aw_held = 1'b1;
         r_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && r_q.wready) begin
         r_d.w_held = 1'b1;
         r_d.wdata = s_axi_wdata;
         r_d.wstrb = s_axi_wstrb;
      end
      if (r_q.bvalid && s_axi_bready) begin
         r_d.bvalid = 1'b0;
      end
      if (r_q.rvalid && s_axi_rready) begin
         r_d.rvalid = 1'b0;
      end
      do_write = r_q.aw_held && r_q.w_held && !r_q.bvalid;
      do_read = s_axi_arvalid && r_q.arready;

      // ========================================================
      // register writes
      if (do_write) begin
         r_d.aw_held = 1'b0;
         r_d.w_held = 1'b0;
         r_d.bvalid = 1'b1;
         unique case (r_q.awaddr)
            scbc_pkg::OFS_CTRL: go = r_q.wstrb[0] && r_q.wdata[scbc_pkg::CTRL_GO_BIT];
            scbc_pkg::OFS_OPA_LO: r_d.opa_lo = merge16(r_q.opa_lo, r_q.wdata, r_q.wstrb);
            scbc_pkg::OFS_OPA_HI: r_d.opa_hi = merge16(r_q.opa_hi, r_q.wdata, r_q.wstrb);
            scbc_pkg::OFS_OPB_LO: r_d.opb_lo = merge16(r_q.opb_lo, r_q.wdata, r_q.wstrb);
            scbc_pkg::OFS_OPB_HI: r_d.opb_hi = merge16(r_q.opb_hi, r_q.wdata, r_q.wstrb);
            scbc_pkg::OFS_PTR: r_d.ptr = merge16(r_q.ptr, r_q.wdata, r_q.wstrb);
            scbc_pkg::OFS_IRQ_MASK: begin
               if (r_q.wstrb[0]) begin
                  r_d.irq_mask = r_q.wdata[1:0];
               end
            end
            scbc_pkg::OFS_RES_LO, scbc_pkg::OFS_RES_HI, scbc_pkg::OFS_FLAGS,
            scbc_pkg::OFS_IRQ_STAT: map_ok = 1'b1;
            default: map_ok = 1'b0;
         endcase
         r_d.bresp = map_ok ? scbc_pkg::RESP_OKAY : scbc_pkg::RESP_SLVERR;
      end

      // ========================================================
      // instruction launch; a launch while busy is dropped
      if (go && r_q.st == SCBC_IDLE && go_exec && go_op != scbc_pkg::OP_NONE) begin
         r_d.op = go_op;
         // the pointer fault stops the launch, so no result word moves
         if (ptr_fault) begin
            r_d.fault = 1'b1;
            ev = 2'b11;
         end else if (go_op == scbc_pkg::OP_CMP) begin
            r_d.fault = 1'b0;
            r_d.above = cmp_a > cmp_b;
            r_d.match = cmp_a == cmp_b;
            r_d.below = cmp_a < cmp_b;
            ev[scbc_pkg::IRQ_DONE_BIT] = 1'b1;
         end else begin
            cv_start = 1'b1;
            cv_ndigits = (go_op == scbc_pkg::OP_CVT_WORD) ? scbc_pkg::DIGITS_WORD
                                                          : scbc_pkg::DIGITS_LONG;
            r_d.st = SCBC_CONV;
         end
      end

      // ========================================================
      // conversion completion; sources are never touched here
      if (r_q.st == SCBC_CONV && cv_done) begin
         r_d.st = SCBC_IDLE;
         ev[scbc_pkg::IRQ_DONE_BIT] = 1'b1;
         if (cv_bad) begin
            r_d.fault = 1'b1;
            ev[scbc_pkg::IRQ_FAULT_BIT] = 1'b1;
         end else begin
            r_d.fault = 1'b0;
            r_d.res_lo = cv_value[15:0];
            if (r_q.op == scbc_pkg::OP_CVT_LONG) begin
               r_d.res_hi = cv_value[31:16];
            end
            // match is the only compare flag a conversion touches
            r_d.match = cv_value == 32'h0000_0000;
         end
      end

      // ========================================================
      // register reads; status read clears, a same-cycle event survives
      if (do_read) begin
         r_d.rvalid = 1'b1;
         r_d.rresp = scbc_pkg::RESP_OKAY;
         r_d.rdata = 32'h0000_0000;
         unique case (s_axi_araddr)
            scbc_pkg::OFS_CTRL: r_d.rdata = {30'h0, r_q.op};
            scbc_pkg::OFS_OPA_LO: r_d.rdata = {16'h0000, r_q.opa_lo};
            scbc_pkg::OFS_OPA_HI: r_d.rdata = {16'h0000, r_q.opa_hi};
            scbc_pkg::OFS_OPB_LO: r_d.rdata = {16'h0000, r_q.opb_lo};
            scbc_pkg::OFS_OPB_HI: r_d.rdata = {16'h0000, r_q.opb_hi};
            scbc_pkg::OFS_RES_LO: r_d.rdata = {16'h0000, r_q.res_lo};
            scbc_pkg::OFS_RES_HI: r_d.rdata = {16'h0000, r_q.res_hi};
            scbc_pkg::OFS_PTR: r_d.rdata = {16'h0000, r_q.ptr};
            scbc_pkg::OFS_FLAGS: begin
               r_d.rdata[scbc_pkg::FLG_ABOVE_BIT] = r_q.above;
               r_d.rdata[scbc_pkg::FLG_MATCH_BIT] = r_q.match;
               r_d.rdata[scbc_pkg::FLG_BELOW_BIT] = r_q.below;
               r_d.rdata[scbc_pkg::FLG_FAULT_BIT] = r_q.fault;
               r_d.rdata[scbc_pkg::FLG_BUSY_BIT] = r_q.st == SCBC_CONV;
            end
            scbc_pkg::OFS_IRQ_STAT: begin
               r_d.rdata = {30'h0, r_q.irq_stat};
               r_d.irq_stat = 2'b00;
            end
            scbc_pkg::OFS_IRQ_MASK: r_d.rdata = {30'h0, r_q.irq_mask};
            default: r_d.rresp = scbc_pkg::RESP_SLVERR;
         endcase
      end
      r_d.irq_stat = r_d.irq_stat | ev;

      // ========================================================
      // ready flags
      // registered so every output comes from a flop; both stay low while
      // a write answer waits, so no second write is taken behind it
      r_d.awready = !r_d.aw_held && !r_d.bvalid && !(r_q.awready && s_axi_awvalid);
      r_d.wready = !r_d.w_held && !r_d.bvalid && !(r_q.wready && s_axi_wvalid);
      r_d.arready = !r_d.rvalid && !do_read;
      r_d.irq = |(r_d.irq_stat & r_d.irq_mask);
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_q <= '0;
         r_q.st <= SCBC_IDLE;
         r_q.irq_mask <= scbc_pkg::IRQ_MASK_RST;
      end else begin
         r_q <= r_d;
      end
   end

   // ==========================================================
   // outputs
   // plain wires from the state flops
   assign s_axi_awready = r_q.awready;
   assign s_axi_wready = r_q.wready;
   assign s_axi_bvalid = r_q.bvalid;
   assign s_axi_bresp = r_q.bresp;
   assign s_axi_arready = r_q.arready;
   assign s_axi_rvalid = r_q.rvalid;
   assign s_axi_rdata = r_q.rdata;
   assign s_axi_rresp = r_q.rresp;
   assign irq = r_q.irq;
endmodule : scbc_top

/* File: tb/scbc_seq_model.sv */
// bus master model standing in for the instruction sequencer
module scbc_seq_model (
   input wire logic clk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====
   // bus cycles
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
   end
   // released lines show the inverse so a stale value is never trusted
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
         if (s_axi_bvalid) break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : scbc_seq_model

/* File: tb/scbc_properties.sv */
// handshake and read-back checks on the unit's bus ports
module scbc_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (rst);
   // ====
   // address of the read under way
   logic [7:0] ra_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ra_q <= 8'h00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         ra_q <= s_axi_araddr;
      end
   end
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write not answered");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_bvalid_retire: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not retired");
   a_rvalid_retire: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response not retired");
   a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("address taken while read pending");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_flags_exclusive: assert property (
      s_axi_rvalid && ra_q == scbc_pkg::OFS_FLAGS |-> !(s_axi_rdata[0] && s_axi_rdata[2]))
      else $error("above and below both set");
   a_read_resp: assert property (s_axi_rvalid && ra_q[1:0] == 2'h0 |-> s_axi_rresp ==
      (ra_q > scbc_pkg::OFS_IRQ_MASK ? scbc_pkg::RESP_SLVERR : scbc_pkg::RESP_OKAY))
      else $error("wrong read response code");
endmodule : scbc_properties
bind scbc_top scbc_properties u_props (.*);

/* File: tb/scbc_top_tb.sv */
// self-checking bench for the compare and convert unit
module scbc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv, res;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   int n_fail = 0, comparisons = 0, cyc = 0;
   // small area end so the past-the-end pointer is cheap to reach
   scbc_top #(.AREA_LAST_BCD(16'h0100)) u_dut (.*);
   scbc_seq_model u_seq (.*);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         test_done();
      end
   end
   // ====
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_seq.wr(a, d, rr);
      chk({30'h0, rr}, {30'h0, scbc_pkg::RESP_OKAY});
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      u_seq.rd(a, rv, rr);
      chk(rv, e);
   endtask : rdc
   task automatic wop(input logic [7:0] a, input logic [31:0] v);
      wr(a, {16'h0, v[15:0]});
      wr(a + 8'h04, {16'h0, v[31:16]});
   endtask : wop
   // flags are polled from launch until busy clears, at most 50 reads, before anything can overwrite them
   task automatic run(input logic [1:0] op, input logic ex, input logic ind);
      int n;
      wr(scbc_pkg::OFS_CTRL, {24'h0, 2'b10, ind, ex, 2'b00, op});
      n = 0;
      do begin
         u_seq.rd(scbc_pkg::OFS_FLAGS, rv, rr);
         n++;
      end while (rv[scbc_pkg::FLG_BUSY_BIT] !== 1'b0 && n < 50);
   endtask : run
   task automatic cvt(input logic [1:0] op, input logic [31:0] s, input logic [31:0] e,
      input logic bad);
      wop(scbc_pkg::OFS_OPA_LO, s);
      run(op, 1'b1, 1'b0);
      chk({31'h0, rv[3]}, {31'h0, bad});
      if (!bad) begin
         chk({31'h0, rv[1]}, {31'h0, e == 32'h0});
         res = (op == scbc_pkg::OP_CVT_WORD) ? {res[31:16], e[15:0]} : e;
      end
      rdc(scbc_pkg::OFS_RES_LO, {16'h0, res[15:0]});
      rdc(scbc_pkg::OFS_RES_HI, {16'h0, res[31:16]});
      rdc(scbc_pkg::OFS_OPA_LO, {16'h0, s[15:0]});
   endtask : cvt
   // ====
   // scenarios
   task automatic t_compare();
      logic [31:0] a [4] = '{32'h5, 32'hffff_fffe, 32'h0001_0000, 32'h8000_0000};
      logic [31:0] b [4] = '{32'h5, 32'h1, 32'h0000_ffff, 32'h7fff_ffff};
      logic [2:0] e [4] = '{3'b010, 3'b100, 3'b001, 3'b100};
      for (int i = 0; i < 4; i++) begin
         wop(scbc_pkg::OFS_OPA_LO, a[i]);
         wop(scbc_pkg::OFS_OPB_LO, b[i]);
         run(scbc_pkg::OP_CMP, 1'b1, 1'b0);
         chk({29'h0, rv[2:0]}, {29'h0, e[i]});
      end
      wop(scbc_pkg::OFS_OPA_LO, 32'h7fff_ffff);
      run(scbc_pkg::OP_CMP, 1'b0, 1'b0);
      chk({29'h0, rv[2:0]}, 32'h4);
      run(scbc_pkg::OP_NONE, 1'b1, 1'b0);
      chk({29'h0, rv[2:0]}, 32'h4);
      rdc(scbc_pkg::OFS_CTRL, {30'h0, scbc_pkg::OP_CMP});
   endtask : t_compare
   task automatic t_convert();
      res = 32'h0;
      cvt(scbc_pkg::OP_CVT_WORD, 32'h1234, 32'h04d2, 1'b0);
      cvt(scbc_pkg::OP_CVT_WORD, 32'h0, 32'h0, 1'b0);
      cvt(scbc_pkg::OP_CVT_LONG, 32'h1234_5678, 32'h00bc_614e, 1'b0);
      cvt(scbc_pkg::OP_CVT_LONG, 32'h9999_9999, 32'h05f5_e0ff, 1'b0);
      cvt(scbc_pkg::OP_CVT_WORD, 32'h9999, 32'h270f, 1'b0);
      cvt(scbc_pkg::OP_CVT_WORD, 32'h12a4, 32'h0, 1'b1);
      cvt(scbc_pkg::OP_CVT_LONG, 32'h9f00_1111, 32'h0, 1'b1);
   endtask : t_convert
   task automatic t_indirect();
      logic [15:0] p [3] = '{16'h12ab, 16'h0101, 16'h0100};
      for (int i = 0; i < 3; i++) begin
         wr(scbc_pkg::OFS_PTR, {16'h0, p[i]});
         run(scbc_pkg::OP_CVT_WORD, 1'b1, 1'b1);
         chk({31'h0, rv[3]}, {31'h0, i < 2});
         // the area end itself is legal, so 1111 decimal converts
         if (i == 2) begin
            res[15:0] = 16'h0457;
         end
         rdc(scbc_pkg::OFS_RES_LO, {16'h0, res[15:0]});
      end
   endtask : t_indirect
   task automatic t_irq();
      rdc(scbc_pkg::OFS_IRQ_MASK, 32'h0);
      u_seq.rd(scbc_pkg::OFS_IRQ_STAT, rv, rr);
      run(scbc_pkg::OP_CMP, 1'b1, 1'b0);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      rdc(scbc_pkg::OFS_IRQ_STAT, 32'h1);
      rdc(scbc_pkg::OFS_IRQ_STAT, 32'h0);
      wr(scbc_pkg::OFS_IRQ_MASK, 32'h1);
      run(scbc_pkg::OP_CMP, 1'b1, 1'b0);
      @(negedge clk);
      chk({31'h0, irq}, 32'h1);
      rdc(scbc_pkg::OFS_IRQ_STAT, 32'h1);
      repeat (2) @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      u_seq.wr(8'h40, 32'h0, rr);
      chk({30'h0, rr}, {30'h0, scbc_pkg::RESP_SLVERR});
      u_seq.rd(8'h40, rv, rr);
      chk({30'h0, rr}, {30'h0, scbc_pkg::RESP_SLVERR});
   endtask : t_irq
   task automatic test_done();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done
   initial begin
      rst = 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_irq();
      t_compare();
      t_convert();
      t_indirect();
      test_done();
   end
endmodule : scbc_top_tb
